/* inc/bte_consts.svh */
// register offsets, field positions, reset values and timing for the tester
`ifndef BTE_CONSTS_SVH
`define BTE_CONSTS_SVH

`define BTE_ADDR_W 8
`define BTE_OFF_CTRL 8'h00
`define BTE_OFF_CMD 8'h04
`define BTE_OFF_STAT 8'h08
`define BTE_OFF_SNAP 8'h0c
`define BTE_OFF_SNAP_END 8'h24
`define BTE_OFF_RATIO 8'h28
`define BTE_OFF_SAVED 8'h2c

`define BTE_CTRL_PAT_LSB 0
`define BTE_CTRL_DIR_BIT 4
`define BTE_CTRL_SEC_BIT 8

`define BTE_CMD_SAVE 0
`define BTE_CMD_UNDO 1
`define BTE_CMD_REFRESH 2
`define BTE_CMD_INJECT 3
`define BTE_CMD_RESTART 4

`define BTE_STAT_LOCK 0
`define BTE_STAT_LOOP 1
`define BTE_STAT_CONSECUTIVE_SEVERE_COUNT_ON 2
`define BTE_STAT_BUSY 3
`define BTE_STAT_SEC_AVAIL 4
`define BTE_STAT_LB_LSB 8

`define BTE_HIST_RST 20'hfffff
`define BTE_SYNC_GOOD 32
`define BTE_WIN_BITS 64
`define BTE_LOSS_ERRS 8
`define BTE_SEVERE_RUN 10
`define BTE_SEVERE_DEN 1000
`define BTE_QRSS_ZEROS 14
`define BTE_DIV_STEPS 32

`define BTE_SEC_NS 1000000000
`define BTE_CLK_NS 4

`endif

/* inc/bte_pkg.sv */
// types shared by the test engine
package bte_pkg;

  typedef enum logic [2:0] {
    PAT_OFF = 3'h0,
    PAT_MARK = 3'h1,
    PAT_SPACE = 3'h2,
    PAT_ALT = 3'h3,
    PAT_BYTE = 3'h4,
    PAT_P511 = 3'h5,
    PAT_P2047 = 3'h6,
    PAT_QRSS = 3'h7
  } bte_pat_t;

  typedef enum logic [1:0] {
    DV_IDLE = 2'b01,
    DV_RUN = 2'b10
  } bte_div_t;

  typedef struct packed {
    logic [2:0] sync1;
    logic [2:0] sync2;
    bte_pat_t pend_pat;
    logic pend_dir;
    logic pend_sec;
    bte_pat_t pat;
    logic dir;
    logic sec;
    logic [19:0] tx_hist;
    logic [19:0] rx_hist;
    logic [2:0] phase;
    logic inject;
    logic tx_bit;
    logic locked;
    logic [5:0] good_run;
    logic [5:0] win_cnt;
    logic [3:0] win_err;
    logic [27:0] sec_cnt;
    logic [31:0] sec_err;
    logic [31:0] sec_bits;
    logic sec_unlk;
    logic [3:0] sev_run;
    logic [3:0] ok_run;
    logic consecutive_severe_count_on;
    logic [6:0][31:0] stat;
    logic [6:0][31:0] snap;
    logic [31:0] ratio;
    bte_div_t dv_state;
    logic [32:0] dv_rem;
    logic [31:0] dv_den;
    logic [31:0] dv_q;
    logic [5:0] dv_n;
  } bte_state_t;

endpackage : bte_pkg

/* src/bte_engine.sv */
// bit error rate test engine with apb register access
// Notes on behaviour
// - patterns: off, ones, zeros, 1010, 0100-0000, 511, 2047, quasi-random.
// - network direction sends the pattern toward the wide-area network.
// - user direction sends the pattern toward the four-wire loop.
// - primary or secondary channel; secondary refused when the port has none.
// - lock flag shows the receiver is synchronised to the expected pattern.
// - every received bit differing from the expected bit while locked is counted.
// - errored seconds count seconds holding at least one bit error.
// - severe seconds count seconds whose error ratio exceeds one per thousand.
// - ten severe seconds in a row start the consecutive count, one per second.
// - ten non-severe seconds in a row stop the consecutive count.
// - seconds with the receiver out of lock are counted.
// - error ratio is bit errors divided by bits sent since the start.
// - whole seconds since the test started are counted.
// - loop status reads normal with signal present, else no signal.
// - inject command inverts exactly one transmitted pattern bit.
// - refresh takes a snapshot of all counters for reading; a refresh while the divider is busy is dropped.
// - settings act only when saved; undo restores the saved values.
`include "bte_consts.svh"

module bte_engine #(
  parameter int SEC_CYCLES = `BTE_SEC_NS / `BTE_CLK_NS
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [`BTE_ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // card side, same clock
  input wire logic bit_strobe,
  input wire logic secondary_present,
  input wire logic [1:0] loopback_state,
  // line pins
  input wire logic rx_net_pin,
  input wire logic rx_user_pin,
  input wire logic loop_signal_pin,
  output logic tx_net_bit,
  output logic tx_net_en,
  output logic tx_user_bit,
  output logic tx_user_en,
  output logic tx_sec_sel,
  output logic test_lock,
  output logic loop_signal_status
);

  localparam logic [27:0] SEC_LAST = 28'(SEC_CYCLES - 1);

  bte_pkg::bte_state_t s_r;
  bte_pkg::bte_state_t s_nxt;

  function automatic logic [31:0] sat_inc(input logic [31:0] v);
    sat_inc = (v == 32'hffffffff) ? v : v + 32'h1;
  endfunction : sat_inc

  // next pattern bit from a history of earlier bits; the receiver uses the
  // same taps so it self-synchronises to a returned or remote pattern
  function automatic logic pat_bit(input bte_pkg::bte_pat_t p,
                                   input logic [19:0] h);
    case (p)
      bte_pkg::PAT_MARK: pat_bit = 1'b1;
      bte_pkg::PAT_ALT: pat_bit = ~h[0];
      bte_pkg::PAT_BYTE: pat_bit = h[7];
      bte_pkg::PAT_P511: pat_bit = h[8] ^ h[4];
      bte_pkg::PAT_P2047: pat_bit = h[10] ^ h[8];
      bte_pkg::PAT_QRSS: pat_bit = h[19] ^ h[16];
      default: pat_bit = 1'b0;
    endcase
  endfunction : pat_bit

  logic wr_en;
  logic rx_bit;
  logic running;
  logic tick;
  logic gen;
  logic err;
  logic severe;
  logic do_save;
  logic do_undo;
  logic do_refresh;
  logic do_inject;
  logic do_restart;
  logic [3:0] win_sum;
  logic [32:0] dv_shift;
  logic [41:0] err_scaled;

  always_comb begin
    s_nxt = s_r;
    wr_en = psel & penable & pwrite;
    do_save = 1'b0;
    do_undo = 1'b0;
    do_refresh = 1'b0;
    do_inject = 1'b0;
    do_restart = 1'b0;
    s_nxt.sync1 = {loop_signal_pin, rx_user_pin, rx_net_pin};
    s_nxt.sync2 = s_r.sync1;
    rx_bit = s_r.dir ? s_r.sync2[1] : s_r.sync2[0];
    running = s_r.pat != bte_pkg::PAT_OFF;
    tick = s_r.sec_cnt == SEC_LAST;
    gen = 1'b0;
    err = 1'b0;
    win_sum = 4'h0;
    err_scaled = 42'(s_r.sec_err) * 42'(`BTE_SEVERE_DEN);
    severe = err_scaled > 42'(s_r.sec_bits);
    dv_shift = {s_r.dv_rem[31:0], 1'b0};

    // register writes: control is only a pending copy until saved
    if (wr_en && paddr == `BTE_OFF_CTRL) begin
      s_nxt.pend_pat = bte_pkg::bte_pat_t'(pwdata[`BTE_CTRL_PAT_LSB +: 3]);
      s_nxt.pend_dir = pwdata[`BTE_CTRL_DIR_BIT];
      s_nxt.pend_sec = pwdata[`BTE_CTRL_SEC_BIT];
    end else if (wr_en && paddr == `BTE_OFF_CMD) begin
      do_save = pwdata[`BTE_CMD_SAVE];
      do_undo = pwdata[`BTE_CMD_UNDO];
      do_refresh = pwdata[`BTE_CMD_REFRESH];
      do_inject = pwdata[`BTE_CMD_INJECT];
      do_restart = pwdata[`BTE_CMD_RESTART];
    end

    // one-second divider free-runs on the card clock
    // save and restart zero it, so every test starts on a whole second
    s_nxt.sec_cnt = tick ? 28'h0 : s_r.sec_cnt + 28'h1;

    // transmit side
    // the history keeps raw bits so zero suppression never bends the sequence
    if (bit_strobe && running) begin
      if (s_r.pat == bte_pkg::PAT_BYTE) begin
        gen = s_r.phase == 3'h1;
      end else begin
        gen = pat_bit(s_r.pat, s_r.tx_hist);
      end
      s_nxt.tx_hist = {s_r.tx_hist[18:0], gen};
      s_nxt.phase = s_r.phase + 3'h1;
      if (s_r.pat == bte_pkg::PAT_QRSS &&
          {s_r.tx_hist[`BTE_QRSS_ZEROS-2:0], gen} == '0) begin
        gen = 1'b1;
      end
      s_nxt.tx_bit = gen ^ s_r.inject;
      s_nxt.inject = 1'b0;
    end
    if (do_inject && running) begin
      s_nxt.inject = 1'b1;
    end

    // receive side: errors are only trusted once locked
    // lock needs a clean run; loss needs a dense burst within one window
    if (bit_strobe && running) begin
      err = rx_bit ^ pat_bit(s_r.pat, s_r.rx_hist);
      s_nxt.rx_hist = {s_r.rx_hist[18:0], rx_bit};
      s_nxt.stat[6] = sat_inc(s_r.stat[6]);
      s_nxt.sec_bits = sat_inc(s_r.sec_bits);
      if (!s_r.locked) begin
        s_nxt.sec_unlk = 1'b1;
        s_nxt.good_run = err ? 6'h0 : s_r.good_run + 6'h1;
        if (!err && s_r.good_run == 6'(`BTE_SYNC_GOOD - 1)) begin
          s_nxt.locked = 1'b1;
          s_nxt.win_cnt = 6'h0;
          s_nxt.win_err = 4'h0;
        end
      end else begin
        win_sum = s_r.win_err + {3'h0, err};
        s_nxt.win_cnt = s_r.win_cnt + 6'h1;
        s_nxt.win_err = (s_r.win_cnt == 6'(`BTE_WIN_BITS - 1)) ? 4'h0 : win_sum;
        if (win_sum == 4'(`BTE_LOSS_ERRS)) begin
          s_nxt.locked = 1'b0;
          s_nxt.good_run = 6'h0;
        end
        if (err) begin
          s_nxt.stat[0] = sat_inc(s_r.stat[0]);
          s_nxt.sec_err = sat_inc(s_r.sec_err);
        end
      end
    end

    // per-second statistics
    if (tick && running) begin
      s_nxt.stat[5] = sat_inc(s_r.stat[5]);
      if (s_r.sec_err != 32'h0) begin
        s_nxt.stat[1] = sat_inc(s_r.stat[1]);
      end
      if (severe) begin
        s_nxt.stat[2] = sat_inc(s_r.stat[2]);
      end
      if (s_r.sec_unlk || !s_r.locked) begin
        s_nxt.stat[4] = sat_inc(s_r.stat[4]);
      end
      // a run holds at its limit while it grows; the other kind clears it
      s_nxt.sev_run = severe ? s_r.sev_run + 4'h1 : 4'h0;
      s_nxt.ok_run = severe ? 4'h0 : s_r.ok_run + 4'h1;
      if (severe && s_r.sev_run == 4'(`BTE_SEVERE_RUN)) begin
        s_nxt.sev_run = s_r.sev_run;
      end
      if (!severe && s_r.ok_run == 4'(`BTE_SEVERE_RUN)) begin
        s_nxt.ok_run = s_r.ok_run;
      end
      if (!s_r.consecutive_severe_count_on && severe &&
          s_r.sev_run == 4'(`BTE_SEVERE_RUN - 1)) begin
        s_nxt.consecutive_severe_count_on = 1'b1;
      end
      if (s_r.consecutive_severe_count_on && !severe &&
          s_r.ok_run == 4'(`BTE_SEVERE_RUN - 1)) begin
        s_nxt.consecutive_severe_count_on = 1'b0;
      end
      if (s_r.consecutive_severe_count_on) begin
        s_nxt.stat[3] = sat_inc(s_r.stat[3]);
      end
      // the strobe on the tick edge already belongs to the new second
      s_nxt.sec_err = {31'h0, bit_strobe & s_r.locked & err};
      s_nxt.sec_bits = {31'h0, bit_strobe};
      s_nxt.sec_unlk = bit_strobe & ~s_r.locked;
    end

    // serial divider for the ratio, 2^-32 units, one quotient bit a cycle
    // a refresh while busy is dropped so snapshot and ratio stay paired
    case (s_r.dv_state)
      bte_pkg::DV_IDLE: begin
        if (do_refresh) begin
          s_nxt.snap = s_r.stat;
          s_nxt.dv_rem = {1'b0, s_r.stat[0]};
          s_nxt.dv_den = s_r.stat[6];
          s_nxt.dv_q = 32'h0;
          s_nxt.dv_n = 6'h0;
          if (s_r.stat[6] == 32'h0) begin
            s_nxt.ratio = 32'h0;
          end else if (s_r.stat[0] >= s_r.stat[6]) begin
            s_nxt.ratio = 32'hffffffff;
          end else begin
            s_nxt.dv_state = bte_pkg::DV_RUN;
          end
        end
      end
      bte_pkg::DV_RUN: begin
        if (dv_shift >= {1'b0, s_r.dv_den}) begin
          s_nxt.dv_rem = dv_shift - {1'b0, s_r.dv_den};
          s_nxt.dv_q = {s_r.dv_q[30:0], 1'b1};
        end else begin
          s_nxt.dv_rem = dv_shift;
          s_nxt.dv_q = {s_r.dv_q[30:0], 1'b0};
        end
        s_nxt.dv_n = s_r.dv_n + 6'h1;
        if (s_r.dv_n == 6'(`BTE_DIV_STEPS - 1)) begin
          s_nxt.ratio = s_nxt.dv_q;
          s_nxt.dv_state = bte_pkg::DV_IDLE;
        end
      end
      default: s_nxt.dv_state = bte_pkg::DV_IDLE;
    endcase

    // settings commands; save also starts a fresh test
    if (do_undo) begin
      s_nxt.pend_pat = s_r.pat;
      s_nxt.pend_dir = s_r.dir;
      s_nxt.pend_sec = s_r.sec;
    end else if (do_save) begin
      s_nxt.pat = s_r.pend_pat;
      s_nxt.dir = s_r.pend_dir;
      s_nxt.sec = s_r.pend_sec & secondary_present;
      // the pending copy is masked too, so a read-back shows what is in force
      s_nxt.pend_sec = s_r.pend_sec & secondary_present;
    end
    if (do_save || do_restart) begin
      s_nxt.stat = '0;
      s_nxt.sec_err = 32'h0;
      s_nxt.sec_bits = 32'h0;
      s_nxt.sec_unlk = 1'b0;
      s_nxt.sev_run = 4'h0;
      s_nxt.ok_run = 4'h0;
      s_nxt.consecutive_severe_count_on = 1'b0;
      s_nxt.locked = 1'b0;
      s_nxt.good_run = 6'h0;
      s_nxt.tx_hist = `BTE_HIST_RST;
      s_nxt.phase = 3'h0;
      s_nxt.inject = 1'b0;
      s_nxt.sec_cnt = 28'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // enum fields get legal codes; a plain zero fill would leave dv_state illegal
      s_r <= '0;
      s_r.pend_pat <= bte_pkg::PAT_OFF;
      s_r.pat <= bte_pkg::PAT_OFF;
      s_r.tx_hist <= `BTE_HIST_RST;
      s_r.dv_state <= bte_pkg::DV_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // apb read path; unmapped addresses answer with an error
  // a live mux of paddr: only meaningful in the access phase
  always_comb begin
    prdata = 32'h0;
    pslverr = 1'b0;
    if (paddr == `BTE_OFF_CTRL) begin
      prdata[`BTE_CTRL_PAT_LSB +: 3] = s_r.pend_pat;
      prdata[`BTE_CTRL_DIR_BIT] = s_r.pend_dir;
      prdata[`BTE_CTRL_SEC_BIT] = s_r.pend_sec;
    end else if (paddr == `BTE_OFF_SAVED) begin
      prdata[`BTE_CTRL_PAT_LSB +: 3] = s_r.pat;
      prdata[`BTE_CTRL_DIR_BIT] = s_r.dir;
      prdata[`BTE_CTRL_SEC_BIT] = s_r.sec;
    end else if (paddr == `BTE_OFF_CMD) begin
      prdata = 32'h0;
    end else if (paddr == `BTE_OFF_STAT) begin
      prdata[`BTE_STAT_LOCK] = s_r.locked;
      prdata[`BTE_STAT_LOOP] = s_r.sync2[2];
      prdata[`BTE_STAT_CONSECUTIVE_SEVERE_COUNT_ON] = s_r.consecutive_severe_count_on;
      prdata[`BTE_STAT_BUSY] = s_r.dv_state == bte_pkg::DV_RUN;
      prdata[`BTE_STAT_SEC_AVAIL] = secondary_present;
      prdata[`BTE_STAT_LB_LSB +: 2] = loopback_state;
    end else if (paddr >= `BTE_OFF_SNAP && paddr <= `BTE_OFF_SNAP_END &&
                 paddr[1:0] == 2'h0) begin
      prdata = s_r.snap[3'((paddr - `BTE_OFF_SNAP) >> 2)];
    end else if (paddr == `BTE_OFF_RATIO) begin
      prdata = s_r.ratio;
    end else begin
      pslverr = psel & penable;
    end
  end

  assign pready = 1'b1;
  // the idle line holds the last bit; enables mark which side is driven
  assign tx_net_bit = s_r.tx_bit;
  assign tx_user_bit = s_r.tx_bit;
  assign tx_net_en = (s_r.pat != bte_pkg::PAT_OFF) & ~s_r.dir;
  assign tx_user_en = (s_r.pat != bte_pkg::PAT_OFF) & s_r.dir;
  assign tx_sec_sel = s_r.sec;
  assign test_lock = s_r.locked;
  assign loop_signal_status = s_r.sync2[2];

endmodule : bte_engine

/* testbench/bte_engine_props.sv */
// port assertions for the test engine
`include "bte_consts.svh"
module bte_props (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic [`BTE_ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // card and line
  input wire logic bit_strobe,
  input wire logic secondary_present,
  input wire logic [1:0] loopback_state,
  input wire logic loop_signal_pin,
  input wire logic tx_net_bit,
  input wire logic tx_net_en,
  input wire logic tx_user_bit,
  input wire logic tx_user_en,
  input wire logic tx_sec_sel,
  input wire logic test_lock,
  input wire logic loop_signal_status
);
  default clocking dcb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic rd, wr, sv;
  assign rd = psel && penable && !pwrite;
  assign wr = psel && penable && pwrite;
  assign sv = rd && paddr == `BTE_OFF_SAVED && prdata[2:0] != 3'h0;
  chk_ready_high: assert property (pready) else $error("pready low");
  chk_bad_addr: assert property (rd && paddr > `BTE_OFF_SAVED
    |-> pslverr && prdata == 32'h0) else $error("unmapped read");
  chk_stat_pins: assert property (rd && paddr == `BTE_OFF_STAT
    |-> prdata[9:8] == loopback_state && prdata[4] == secondary_present)
    else $error("status mirror wrong");
  chk_sec_forced: assert property (wr && paddr == `BTE_OFF_CMD
    && pwdata[0] && !pwdata[1] && !secondary_present |-> ##2 !tx_sec_sel)
    else $error("secondary without channel");
  chk_dir_excl: assert property (!(tx_net_en && tx_user_en))
    else $error("both directions on");
  chk_off_quiet: assert property (rd && paddr == `BTE_OFF_SAVED
    && prdata[2:0] == 3'h0 |-> !tx_net_en && !tx_user_en)
    else $error("sending while off");
  chk_net_route: assert property (sv && !prdata[4] |-> tx_net_en)
    else $error("net not enabled");
  chk_user_route: assert property (sv && prdata[4] |-> tx_user_en)
    else $error("user not enabled");
  // gated outputs may move one decode later than a write
  chk_tx_hold: assert property (!bit_strobe && !wr && !$past(wr)
    |=> $stable(tx_net_bit) && $stable(tx_user_bit))
    else $error("tx bit moved without strobe");
  chk_lock_strobe: assert property ($rose(test_lock)
    |-> $past(bit_strobe) || $past(bit_strobe, 2)) else $error("lock odd");
  chk_loop_norm: assert property (loop_signal_pin [*4]
    |=> loop_signal_status) else $error("loop not normal");
  chk_loop_nos: assert property (!loop_signal_pin [*4]
    |=> !loop_signal_status) else $error("loop not no-signal");
  cover property ($rose(test_lock));
  cover property (wr && paddr == `BTE_OFF_CMD && pwdata[3]);
  cover property (rd && pslverr);
endmodule : bte_props

bind bte_engine bte_props u_props (.pclk, .presetn, .paddr, .psel, .penable,
  .pwrite, .pwdata, .prdata, .pready, .pslverr, .bit_strobe,
  .secondary_present, .loopback_state, .loop_signal_pin, .tx_net_bit,
  .tx_net_en, .tx_user_bit, .tx_user_en, .tx_sec_sel, .test_lock,
  .loop_signal_status);

/* testbench/bte_far_end.sv */
// far-end test set looping the sent pattern back
module bte_far_end (
  // clock
  input wire logic pclk,
  // line from the engine
  input wire logic tx_net_bit,
  input wire logic tx_net_en,
  input wire logic tx_user_bit,
  input wire logic tx_user_en,
  // test controls
  input wire logic corrupt,
  input wire logic loop_up,
  // line to the engine
  output logic rx_net_pin,
  output logic rx_user_pin,
  output logic loop_signal_pin
);
  logic last_net = 1'b0;
  logic last_user = 1'b0;
  always_ff @(posedge pclk) begin
    if (tx_net_en) last_net <= tx_net_bit;
    if (tx_user_en) last_user <= tx_user_bit;
  end
  // an idle line shows the inverse so stale bits never look valid
  assign rx_net_pin = tx_net_en ? tx_net_bit ^ corrupt : ~last_net;
  assign rx_user_pin = tx_user_en ? tx_user_bit ^ corrupt : ~last_user;
  assign loop_signal_pin = loop_up;
endmodule : bte_far_end

/* testbench/tb_top.sv */
// self-checking bench for the test engine
`include "bte_consts.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, tx_net_bit, tx_net_en, tx_user_bit, tx_user_en;
  logic tx_sec_sel, test_lock, loop_signal_status, rx_net_pin, rx_user_pin;
  logic loop_signal_pin;
  logic bit_strobe = 1'b0;
  logic secondary_present = 1'b1;
  logic [1:0] loopback_state = 2'h2;
  logic corrupt = 1'b0;
  logic loop_up = 1'b1;
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  always #2 pclk = ~pclk;
  bte_engine #(.SEC_CYCLES(200)) u_dut (.pclk, .presetn, .paddr, .psel,
    .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .bit_strobe,
    .secondary_present, .loopback_state, .rx_net_pin, .rx_user_pin,
    .loop_signal_pin, .tx_net_bit, .tx_net_en, .tx_user_bit, .tx_user_en,
    .tx_sec_sel, .test_lock, .loop_signal_status);
  bte_far_end u_far (.pclk, .tx_net_bit, .tx_net_en, .tx_user_bit,
    .tx_user_en, .corrupt, .loop_up, .rx_net_pin, .rx_user_pin,
    .loop_signal_pin);
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      print_verdict();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    check(pready, 32'h1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    check(q, e);
  endtask : rd_chk
  task automatic setup(input logic [31:0] ctrl);
    wr(`BTE_OFF_CTRL, ctrl);
    wr(`BTE_OFF_CMD, 32'h1);
  endtask : setup
  task automatic t_reset();
    rd_chk(`BTE_OFF_CTRL, 32'h0);
    rd_chk(`BTE_OFF_SAVED, 32'h0);
    rd_chk(`BTE_OFF_STAT, 32'h212);
    rd_chk(8'h40, 32'h0);
    check(tx_net_en | tx_user_en | tx_sec_sel, 32'h0);
    loop_up <= 1'b0;
    repeat (6) @(posedge pclk);
    check(loop_signal_status, 32'h0);
    loop_up <= 1'b1;
    repeat (6) @(posedge pclk);
    check(loop_signal_status, 32'h1);
  endtask : t_reset
  task automatic t_settings();
    setup(32'h104);
    rd_chk(`BTE_OFF_SAVED, 32'h104);
    check(tx_sec_sel, 32'h1);
    wr(`BTE_OFF_CTRL, 32'h017);
    rd_chk(`BTE_OFF_SAVED, 32'h104);
    wr(`BTE_OFF_CMD, 32'h2);
    rd_chk(`BTE_OFF_CTRL, 32'h104);
    secondary_present <= 1'b0;
    setup(32'h101);
    rd_chk(`BTE_OFF_SAVED, 32'h001);
    rd_chk(`BTE_OFF_CTRL, 32'h001);
    secondary_present <= 1'b1;
    setup(32'h0);
  endtask : t_settings
  task automatic grab(input logic usr, output logic [63:0] w);
    bit_strobe <= 1'b1;
    repeat (2) @(posedge pclk);
    for (int i = 0; i < 64; i++) begin
      @(posedge pclk);
      w = {w[62:0], usr ? tx_user_bit : tx_net_bit};
    end
    bit_strobe <= 1'b0;
  endtask : grab
  task automatic t_patterns();
    logic [63:0] w;
    logic ok1, ok2;
    int a, b, zr;
    logic [19:0] g;
    for (int p = 1; p < 8; p++) begin
      setup({27'h0, p[0], 1'b0, p[2:0]});
      rd_chk(`BTE_OFF_SAVED, {27'h0, p[0], 1'b0, p[2:0]});
      grab(p[0], w);
      check(p[0] ? tx_user_en : tx_net_en, 32'h1);
      a = (p == 5) ? 9 : (p == 6) ? 11 : 20;
      b = (p == 5) ? 5 : (p == 6) ? 9 : 17;
      ok1 = 1'b1;
      ok2 = 1'b1;
      // either tap orientation gives the same maximal-length sequence
      for (int j = 0; j + a < 64; j++) begin
        ok1 &= w[j] == (w[j + a] ^ w[j + b]);
        ok2 &= w[j] == (w[j + a] ^ w[j + a - b]);
      end
      case (p)
        1: ok1 = &w;
        2: ok1 = ~|w;
        3: ok1 = w[63:2] == w[61:0] && w[1] != w[0];
        4: ok1 = w[63:8] == w[55:0] && $countones(w[7:0]) == 1;
        7: begin
          // raw 20-stage sequence from an all-ones seed; a run of
          // fourteen raw zeros forces the line bit to one
          g = 20'hfffff;
          zr = 0;
          ok1 = 1'b1;
          for (int n = 0; n <= 64; n++) begin
            zr = (g[19] ^ g[16]) ? 0 : zr + 1;
            if (n > 0) ok1 &= w[64 - n] == ((g[19] ^ g[16]) | (zr >= 14));
            g = {g[18:0], g[19] ^ g[16]};
          end
        end
        default: ok1 |= ok2;
      endcase
      check(ok1, 32'h1);
    end
    setup(32'h0);
    rd_chk(`BTE_OFF_SAVED, 32'h0);
  endtask : t_patterns
  task automatic t_inject();
    int z;
    setup(32'h1);
    bit_strobe <= 1'b1;
    wr(`BTE_OFF_CMD, 32'h8);
    z = 0;
    repeat (40) begin
      @(posedge pclk);
      z += !tx_net_bit;
    end
    bit_strobe <= 1'b0;
    check(z, 1);
  endtask : t_inject
  task automatic t_stats();
    logic [31:0] ex [7];
    logic [63:0] r;
    ex = '{32'd138, 32'd12, 32'd12, 32'd12, 32'd1, 32'd25, 32'd5000};
    setup(32'h5);
    // spoil one bit every 50 over the first twelve seconds
    for (int c = 0; c < 5100; c++) begin
      bit_strobe <= c < 5000;
      corrupt <= c >= 100 && c < 2400 && c % 50 == 0;
      @(posedge pclk);
    end
    check(test_lock, 32'h1);
    wr(`BTE_OFF_CMD, 32'h4);
    repeat (40) @(posedge pclk);
    for (int i = 0; i < 7; i++) begin
      rd_chk(8'h0c + 8'(4 * i), ex[i]);
    end
    r = (64'd138 << 32) / 64'd5000;
    rd_chk(`BTE_OFF_RATIO, r[31:0]);
    wr(`BTE_OFF_CMD, 32'h10);
    wr(`BTE_OFF_CMD, 32'h4);
    repeat (40) @(posedge pclk);
    rd_chk(`BTE_OFF_SNAP, 32'h0);
    setup(32'h0);
  endtask : t_stats
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_settings();
    t_patterns();
    t_inject();
    t_stats();
    print_verdict();
  end
endmodule : tb_top
